// ---- design/mfd_decoder.v ----
// Notes on behaviour
// - Word holds a 14-bit code; positions 9 and 10 always read zero.
// - Parity bit 8 rides in the stored word; only odd parity is valid.
// - Each fetched word is loaded into the 16-bit holding register on demand.
// - Opcode field selects one of 10 classes of the 65 basic operations.
// - Opcode field gives the basic function performed.
// - Operand is 8 bits from two fields, bit 04 most significant.
// - Jump index is 6 bits from two fields, bit 07 most significant.
// - Designator is register, skip selector, constant or bit index; bit 11 zero for index.
// - Register use: bits 12-15 number, bit 11 picks lower or upper basic half.
// - Both selector bits zero: designator names a basic-file register directly.
// - Both selector bits one: designator names an extended-file register.
// - One selector bit set: OR low three designator bits with machine register field.
// - Skip-on-bit and load-bit forms OR four bits, indirect designator included.
// - Dual-mode ops choose one of two variants from a word bit.
// - Any op reaching the extended file may also reach the basic file.
`timescale 1ns/10ps
`include "mfd_regs.vh"
module mfd_decoder
(
	input wire i_ref_clk,
	input wire i_srst,
	input wire i_cs_valid,
	input wire [15:0] i_cs_word,
	input wire [3:0] i_first_reg_field,
	input wire [3:0] i_second_reg_field,
	input wire i_err_clr,
	output reg [15:0] o_word_q,
	output reg o_valid_q,
	output reg o_parity_err_q,
	output reg o_parity_err_sticky_q,
	output reg [3:0] o_opcode_q,
	output reg [3:0] o_class_q,
	output reg o_class_illegal_q,
	output reg [7:0] o_operand_q,
	output reg [5:0] o_jump_index_q,
	output reg [4:0] o_designator_q,
	output reg [4:0] o_reg_num_q,
	output reg o_reg_ext_q,
	output reg o_basic_ok_q,
	output reg o_reg_use_q,
	output reg o_skip_sel_use_q,
	output reg o_const_use_q,
	output reg o_bit_index_use_q,
	output reg [3:0] o_bit_index_q,
	output reg o_bit_index_err_q,
	output reg o_dual_mode_jump_q,
	output reg o_skip_on_bit_op_q,
	output reg o_load_bit_op_q,
	output reg o_inverted_q,
	output reg o_variant_q
);
	reg [15:0] word_d;
	wire parity_ok;
	wire [3:0] opc;
	wire var_bit;
	wire sel_a;
	wire sel_b;
	wire [4:0] x_fld;
	wire bit_op;
	wire [4:0] reg_num;
	wire reg_ext;
	wire parity_bad;
	wire [7:0] operand_w;
	wire [5:0] jump_index_w;
	reg use_reg;
	reg use_skip_sel;
	reg use_const;
	reg use_bit_index;
	reg op_dual_jump;
	reg op_skip_bit;
	reg op_load_bit;
	reg [15:0] hold_word_d;
	reg valid_d;
	reg parity_err_d;
	reg parity_err_sticky_d;
	reg [3:0] opcode_d;
	reg [3:0] class_d;
	reg class_illegal_d;
	reg [7:0] operand_d;
	reg [5:0] jump_index_d;
	reg [4:0] designator_d;
	reg [4:0] reg_num_d;
	reg reg_ext_d;
	reg basic_ok_d;
	reg reg_use_d;
	reg skip_sel_use_d;
	reg const_use_d;
	reg bit_index_use_d;
	reg [3:0] bit_index_d;
	reg bit_index_err_d;
	reg dual_mode_jump_d;
	reg skip_on_bit_op_d;
	reg load_bit_op_d;
	reg inverted_d;
	reg variant_d;

	// Unused positions are forced clear so later logic never sees stray bits
	always @*
	begin
		word_d = i_cs_word;
		word_d[`MFD_VEC(`MFD_UNUSED_BIT_A)] = 1'b0;
		word_d[`MFD_VEC(`MFD_UNUSED_BIT_B)] = 1'b0;
	end

	// Parity is taken on the word as fetched, before clearing, so a set unused bit is caught
	mfd_parity u_parity
	(
		.i_word(i_cs_word),
		.o_odd_ok(parity_ok)
	);

	assign opc = word_d[`MFD_VEC(`MFD_OPC_HI):`MFD_VEC(`MFD_OPC_LO)];
	assign var_bit = word_d[`MFD_VEC(`MFD_VAR_BIT)];
	assign sel_a = word_d[`MFD_VEC(`MFD_SEL_A_BIT)];
	assign sel_b = word_d[`MFD_VEC(`MFD_SEL_B_BIT)];
	assign x_fld = word_d[`MFD_VEC(`MFD_X_HI):`MFD_VEC(`MFD_X_LO)];
	assign bit_op = (opc == `MFD_OP_SKIP_BIT) || (opc == `MFD_OP_LOAD_BIT);
	assign parity_bad = ~parity_ok;
	assign operand_w = {word_d[`MFD_VEC(`MFD_OPD_HI_HI):`MFD_VEC(`MFD_OPD_HI_LO)],
		word_d[`MFD_VEC(`MFD_NUM_HI):`MFD_VEC(`MFD_NUM_LO)]};
	assign jump_index_w = {word_d[`MFD_VEC(`MFD_JIDX_MSB_BIT)], x_fld};

	mfd_regsel u_regsel
	(
		.i_x(x_fld),
		.i_sel_a(sel_a),
		.i_sel_b(sel_b),
		.i_bit_op(bit_op),
		.i_first_reg_field(i_first_reg_field),
		.i_second_reg_field(i_second_reg_field),
		.o_reg_num(reg_num),
		.o_ext(reg_ext)
	);

	// One opcode decode feeds both the designator use and the op flags
	always @*
	begin
		use_reg = 1'b0;
		use_skip_sel = 1'b0;
		use_const = 1'b0;
		use_bit_index = 1'b0;
		op_dual_jump = 1'b0;
		op_skip_bit = 1'b0;
		op_load_bit = 1'b0;
		case (opc)
			`MFD_OP_DUAL_JUMP:
			begin
				use_reg = 1'b1;
				op_dual_jump = 1'b1;
			end
			`MFD_OP_SKIP_SEL:
			begin
				use_skip_sel = 1'b1;
			end
			`MFD_OP_SKIP_BIT:
			begin
				// Bit ops never name a register, so register use stays low
				use_bit_index = 1'b1;
				op_skip_bit = 1'b1;
			end
			`MFD_OP_LOAD_BIT:
			begin
				use_bit_index = 1'b1;
				op_load_bit = 1'b1;
			end
			`MFD_OP_BIT_MODIFY:
			begin
				use_bit_index = 1'b1;
			end
			`MFD_OP_CONSTANT:
			begin
				use_const = 1'b1;
			end
			default:
			begin
				// Every other opcode names a register through the designator
				use_reg = 1'b1;
			end
		endcase
	end

	// Fields hold their last word between fetches
	always @*
	begin
		hold_word_d = o_word_q;
		opcode_d = o_opcode_q;
		class_d = o_class_q;
		class_illegal_d = o_class_illegal_q;
		operand_d = o_operand_q;
		jump_index_d = o_jump_index_q;
		designator_d = o_designator_q;
		reg_num_d = o_reg_num_q;
		reg_ext_d = o_reg_ext_q;
		basic_ok_d = o_basic_ok_q;
		reg_use_d = o_reg_use_q;
		skip_sel_use_d = o_skip_sel_use_q;
		const_use_d = o_const_use_q;
		bit_index_use_d = o_bit_index_use_q;
		bit_index_d = o_bit_index_q;
		bit_index_err_d = o_bit_index_err_q;
		dual_mode_jump_d = o_dual_mode_jump_q;
		skip_on_bit_op_d = o_skip_on_bit_op_q;
		load_bit_op_d = o_load_bit_op_q;
		inverted_d = o_inverted_q;
		variant_d = o_variant_q;
		valid_d = i_cs_valid;
		parity_err_d = i_cs_valid & parity_bad;
		parity_err_sticky_d = o_parity_err_sticky_q;
		if (i_err_clr)
			parity_err_sticky_d = 1'b0;
		// Set comes after the clear, so a new error in the clearing cycle still lands
		if (i_cs_valid && parity_bad)
			parity_err_sticky_d = 1'b1;
		if (i_cs_valid)
		begin
			hold_word_d = word_d;
			opcode_d = opc;
			// Codes past the last class are flagged, not dropped
			class_d = opc;
			class_illegal_d = (opc >= `MFD_NUM_CLASSES);
			operand_d = operand_w;
			jump_index_d = jump_index_w;
			designator_d = x_fld;
			reg_num_d = reg_num;
			reg_ext_d = reg_ext;
			// Extended reach never excludes the basic file
			basic_ok_d = 1'b1;
			reg_use_d = use_reg;
			skip_sel_use_d = use_skip_sel;
			const_use_d = use_const;
			bit_index_use_d = use_bit_index;
			bit_index_d = x_fld[3:0];
			bit_index_err_d = use_bit_index & word_d[`MFD_VEC(`MFD_HALF_BIT)];
			dual_mode_jump_d = op_dual_jump;
			skip_on_bit_op_d = op_skip_bit;
			load_bit_op_d = op_load_bit;
			inverted_d = bit_op & var_bit;
			variant_d = var_bit;
		end
	end

	// Outputs come straight from these flip-flops, so downstream timing sees no decode depth
	always @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			// A stale decode must never survive a restart
			o_word_q <= `MFD_WORD_RST;
			o_valid_q <= 1'b0;
			o_parity_err_q <= 1'b0;
			o_parity_err_sticky_q <= 1'b0;
			o_opcode_q <= 4'h0;
			o_class_q <= 4'h0;
			o_class_illegal_q <= 1'b0;
			o_operand_q <= 8'h00;
			o_jump_index_q <= 6'h00;
			o_designator_q <= 5'h00;
			o_reg_num_q <= `MFD_REG_RST;
			o_reg_ext_q <= 1'b0;
			o_basic_ok_q <= 1'b0;
			o_reg_use_q <= 1'b0;
			o_skip_sel_use_q <= 1'b0;
			o_const_use_q <= 1'b0;
			o_bit_index_use_q <= 1'b0;
			o_bit_index_q <= 4'h0;
			o_bit_index_err_q <= 1'b0;
			o_dual_mode_jump_q <= 1'b0;
			o_skip_on_bit_op_q <= 1'b0;
			o_load_bit_op_q <= 1'b0;
			o_inverted_q <= 1'b0;
			o_variant_q <= 1'b0;
		end
		else
		begin
			o_word_q <= hold_word_d;
			o_valid_q <= valid_d;
			o_parity_err_q <= parity_err_d;
			o_parity_err_sticky_q <= parity_err_sticky_d;
			o_opcode_q <= opcode_d;
			o_class_q <= class_d;
			o_class_illegal_q <= class_illegal_d;
			o_operand_q <= operand_d;
			o_jump_index_q <= jump_index_d;
			o_designator_q <= designator_d;
			o_reg_num_q <= reg_num_d;
			o_reg_ext_q <= reg_ext_d;
			o_basic_ok_q <= basic_ok_d;
			o_reg_use_q <= reg_use_d;
			o_skip_sel_use_q <= skip_sel_use_d;
			o_const_use_q <= const_use_d;
			o_bit_index_use_q <= bit_index_use_d;
			o_bit_index_q <= bit_index_d;
			o_bit_index_err_q <= bit_index_err_d;
			o_dual_mode_jump_q <= dual_mode_jump_d;
			o_skip_on_bit_op_q <= skip_on_bit_op_d;
			o_load_bit_op_q <= load_bit_op_d;
			o_inverted_q <= inverted_d;
			o_variant_q <= variant_d;
		end
	end
endmodule

// ---- design/mfd_parity.v ----
`timescale 1ns/10ps
module mfd_parity
(
	input wire [15:0] i_word,
	output wire o_odd_ok
);
	// Parity bit travels inside the word, so the whole word must hold an odd count
	assign o_odd_ok = ^i_word;
endmodule

// ---- design/mfd_regs.vh ----
`ifndef MFD_REGS_VH
`define MFD_REGS_VH

// Word bits are numbered with bit 0 as the most significant position
`define MFD_VEC(n) (15 - (n))

// Field positions, word numbering
`define MFD_OPC_HI 0
`define MFD_OPC_LO 3
`define MFD_VAR_BIT 4
`define MFD_SEL_A_BIT 5
`define MFD_SEL_B_BIT 6
`define MFD_JIDX_MSB_BIT 7
`define MFD_PARITY_BIT 8
`define MFD_UNUSED_BIT_A 9
`define MFD_UNUSED_BIT_B 10
`define MFD_HALF_BIT 11
`define MFD_X_HI 11
`define MFD_X_LO 15
`define MFD_NUM_HI 12
`define MFD_NUM_LO 15
`define MFD_OPD_HI_HI 4
`define MFD_OPD_HI_LO 7

// Field widths
`define MFD_WORD_W 16
`define MFD_OPC_W 4
`define MFD_OPD_W 8
`define MFD_JIDX_W 6
`define MFD_X_W 5
`define MFD_REG_W 5
`define MFD_CLASS_W 4

// Repertoire
`define MFD_NUM_CLASSES 4'ha
`define MFD_NUM_BASIC_OPS 7'h41

// Operation codes of the special cases, plain defaults
`define MFD_OP_DUAL_JUMP 4'h3
`define MFD_OP_SKIP_BIT 4'h6
`define MFD_OP_LOAD_BIT 4'h7
`define MFD_OP_BIT_MODIFY 4'h8
`define MFD_OP_SKIP_SEL 4'h5
`define MFD_OP_CONSTANT 4'h9

// Reset values
`define MFD_WORD_RST 16'h0000
`define MFD_REG_RST 5'h00

`endif

// ---- design/mfd_regsel.v ----
`timescale 1ns/10ps
module mfd_regsel
(
	input wire [4:0] i_x,
	input wire i_sel_a,
	input wire i_sel_b,
	input wire i_bit_op,
	input wire [3:0] i_first_reg_field,
	input wire [3:0] i_second_reg_field,
	output reg [4:0] o_reg_num,
	output reg o_ext
);
	reg [3:0] mli_field;

	always @*
	begin
		mli_field = i_sel_a ? i_first_reg_field : i_second_reg_field;
		o_reg_num = i_x;
		o_ext = 1'b0;
		case ({i_sel_a, i_sel_b})
			2'b00:
			begin
				o_reg_num = i_x;
				o_ext = 1'b0;
			end
			2'b11:
			begin
				o_reg_num = i_x;
				o_ext = 1'b1;
			end
			default:
			begin
				// Bit ops merge the indirect designator too, so four bits join
				if (i_bit_op)
					o_reg_num = {i_x[4], i_x[3:0] | mli_field};
				else
					o_reg_num = {i_x[4:3], i_x[2:0] | mli_field[2:0]};
				o_ext = 1'b0;
			end
		endcase
	end
endmodule

// ---- test/mfd_cs_model.sv ----
`timescale 1ns/10ps
module mfd_cs_model
(
	input wire i_ref_clk,
	input wire i_we,
	input wire i_rd,
	input wire [3:0] i_addr,
	input wire [15:0] i_wdata,
	output reg o_vld,
	output reg [15:0] o_word
);
	reg [15:0] mem [0:15];
	initial o_word = 16'h0000;
	// Parity is stored with the word, never made here
	always @(posedge i_ref_clk)
	begin
		if (i_we)
			mem[i_addr] <= i_wdata;
		o_vld <= i_rd;
		// Idle bus inverts each cycle, so stale data passes only on every second idle cycle
		o_word <= i_rd ? mem[i_addr] : ~o_word;
	end
endmodule

// ---- test/mfd_decoder_checker.sv ----
`timescale 1ns/10ps
module mfd_decoder_checker
(
	input wire i_ref_clk,
	input wire i_srst,
	input wire i_cs_valid,
	input wire [15:0] i_cs_word,
	input wire i_err_clr,
	input wire [15:0] o_word_q,
	input wire o_valid_q,
	input wire o_parity_err_q,
	input wire o_parity_err_sticky_q,
	input wire [3:0] o_opcode_q,
	input wire [7:0] o_operand_q,
	input wire [5:0] o_jump_index_q
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	property p_val;
		i_cs_valid |=> o_valid_q;
	endproperty
	a_val: assert property (p_val) else $error("no valid");
	property p_zero;
		o_word_q[6:5] == 2'b00;
	endproperty
	a_zero: assert property (p_zero) else $error("unused set");
	property p_word;
		i_cs_valid |=> o_word_q == ($past(i_cs_word) & 16'hff9f);
	endproperty
	a_word: assert property (p_word) else $error("bad word");
	property p_par;
		i_cs_valid |=> o_parity_err_q == !(^$past(i_cs_word));
	endproperty
	a_par: assert property (p_par) else $error("bad parity");
	property p_stk;
		o_parity_err_q |-> o_parity_err_sticky_q;
	endproperty
	a_stk: assert property (p_stk) else $error("no sticky");
	property p_opc;
		i_cs_valid |=> o_opcode_q == $past(i_cs_word[15:12]);
	endproperty
	a_opc: assert property (p_opc) else $error("bad opcode");
	property p_opd;
		i_cs_valid |=> o_operand_q == {$past(i_cs_word[11:8]), $past(i_cs_word[3:0])};
	endproperty
	a_opd: assert property (p_opd) else $error("bad operand");
	property p_jmp;
		i_cs_valid |=> o_jump_index_q == {$past(i_cs_word[8]), $past(i_cs_word[4:0])};
	endproperty
	a_jmp: assert property (p_jmp) else $error("bad jump");
	property p_hold;
		!i_srst && !i_cs_valid |=> $stable(o_word_q);
	endproperty
	a_hold: assert property (p_hold) else $error("word moved");
	property p_clr;
		i_err_clr && !(i_cs_valid && !(^i_cs_word)) |=> !o_parity_err_sticky_q;
	endproperty
	a_clr: assert property (p_clr) else $error("sticky kept");
	property p_set;
		i_cs_valid && !(^i_cs_word) |=> o_parity_err_sticky_q;
	endproperty
	a_set: assert property (p_set) else $error("sticky lost");
endmodule
bind mfd_decoder mfd_decoder_checker u_chk (.i_ref_clk, .i_srst, .i_cs_valid, .i_cs_word, .i_err_clr, .o_word_q,
	.o_valid_q, .o_parity_err_q, .o_parity_err_sticky_q, .o_opcode_q, .o_operand_q, .o_jump_index_q);

// ---- test/test_mfd_decoder.sv ----
`timescale 1ns/10ps
`include "mfd_regs.vh"
module test_mfd_decoder;
	reg clk, srst, we, rd, clr;
	reg [3:0] addr, f1, f2;
	reg [15:0] wd, r, w, m [0:15];
	reg [15:0] q [$];
	integer error_cnt = 0, num_checks = 0, cyc = 0, i, p;
	wire vld, vq, perr, stk, ext, vb;
	wire [15:0] cw, word;
	wire [4:0] rnum;
	wire ill, bok, ruse, suse, cuse, buse, berr, dj, sb, lb, inv;
	wire [3:0] opc, cls, bidx;
	wire [7:0] opd;
	wire [5:0] jix;
	wire [4:0] dsg;
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	mfd_cs_model u_cs (.i_ref_clk(clk), .i_we(we), .i_rd(rd), .i_addr(addr), .i_wdata(wd), .o_vld(vld),
		.o_word(cw));
	mfd_decoder uut (.i_ref_clk(clk), .i_srst(srst), .i_cs_valid(vld), .i_cs_word(cw),
		.i_first_reg_field(f1), .i_second_reg_field(f2), .i_err_clr(clr), .o_word_q(word), .o_valid_q(vq),
		.o_parity_err_q(perr), .o_parity_err_sticky_q(stk), .o_opcode_q(opc), .o_class_q(cls),
		.o_class_illegal_q(ill), .o_operand_q(opd), .o_jump_index_q(jix), .o_designator_q(dsg),
		.o_reg_num_q(rnum), .o_reg_ext_q(ext), .o_basic_ok_q(bok), .o_reg_use_q(ruse),
		.o_skip_sel_use_q(suse), .o_const_use_q(cuse), .o_bit_index_use_q(buse), .o_bit_index_q(bidx),
		.o_bit_index_err_q(berr), .o_dual_mode_jump_q(dj), .o_skip_on_bit_op_q(sb), .o_load_bit_op_q(lb),
		.o_inverted_q(inv), .o_variant_q(vb));
	function is_bi(input [3:0] c);
		is_bi = c == `MFD_OP_SKIP_BIT || c == `MFD_OP_LOAD_BIT || c == `MFD_OP_BIT_MODIFY;
	endfunction
	function [15:0] lf(input [15:0] s);
		lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Bit ops merge four bits, others three, only with one selector set
	function [4:0] exp_rn(input [15:0] x);
		reg [3:0] f;
		begin
			f = x[10] ? f1 : f2;
			exp_rn = x[4:0];
			if (x[10] ^ x[9])
				exp_rn = (x[15:12] == `MFD_OP_SKIP_BIT || x[15:12] == `MFD_OP_LOAD_BIT) ?
					{x[4], x[3:0] | f} : {x[4:3], x[2:0] | f[2:0]};
		end
	endfunction
	task chk(input [15:0] s, input [15:0] e);
		begin
			num_checks = num_checks + 1;
			if (s !== e)
			begin
				error_cnt = error_cnt + 1;
				$display("Error %0t got %h want %h", $time, s, e);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d errors %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	always @(posedge clk)
		if (vq === 1'b1)
		begin
			chk(q.size() != 0, 1'b1);
			w = (q.size() != 0) ? q.pop_front() : 16'h0000;
			chk(word, w & 16'hff9f);
			chk(perr, ~^w);
			chk(rnum, exp_rn(w));
			chk(ext, w[10] & w[9]);
			chk(vb, w[11]);
			chk(opc, w[15:12]);
			chk(cls, w[15:12]);
			chk(ill, w[15:12] >= `MFD_NUM_CLASSES);
			chk(opd, {w[11:8], w[3:0]});
			chk(jix, {w[8], w[4:0]});
			chk(dsg, w[4:0]);
			chk(bidx, w[3:0]);
			chk(buse, is_bi(w[15:12]));
			chk(berr, is_bi(w[15:12]) & w[4]);
			chk(suse, w[15:12] == `MFD_OP_SKIP_SEL);
			chk(cuse, w[15:12] == `MFD_OP_CONSTANT);
			chk(ruse, !is_bi(w[15:12]) && w[15:12] != `MFD_OP_SKIP_SEL && w[15:12] != `MFD_OP_CONSTANT);
			chk(dj, w[15:12] == `MFD_OP_DUAL_JUMP);
			chk(sb, w[15:12] == `MFD_OP_SKIP_BIT);
			chk(lb, w[15:12] == `MFD_OP_LOAD_BIT);
			chk(inv, (w[15:12] == `MFD_OP_SKIP_BIT || w[15:12] == `MFD_OP_LOAD_BIT) & w[11]);
			chk(bok, 1'b1);
		end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt = error_cnt + 1;
			give_verdict;
		end
	end
	initial
	begin
		r = 16'h1a68;
		{srst, we, rd, clr, addr, f1, f2, wd} = {1'b1, 31'h0};
		repeat (12) @(posedge clk);
		srst <= 0;
		for (p = 0; p < 4; p = p + 1)
		begin
			for (i = 0; i < 16; i = i + 1)
			begin
				r = lf(r);
				// Each pass walks every opcode once; the rest of the word stays random
				m[i] = {i[3:0], r[11:0]};
				@(posedge clk);
				{we, addr, wd} <= {1'b1, i[3:0], m[i]};
			end
			@(posedge clk);
			{we, f1, f2} <= {1'b0, r[3:0], r[7:4]};
			// Back to back fetches, one word every cycle
			for (i = 0; i < 16; i = i + 1)
			begin
				@(posedge clk);
				{rd, addr} <= {1'b1, i[3:0]};
				q.push_back(m[i]);
			end
			@(posedge clk);
			rd <= 0;
			repeat (4) @(posedge clk);
			$display("pass %0d done", p);
		end
		chk(stk, 1'b1);
		clr <= 1;
		@(posedge clk);
		clr <= 0;
		@(posedge clk);
		chk(stk, 1'b0);
		// A failing word taken in the clearing cycle must still set the flag
		{we, addr, wd} <= {1'b1, 4'h0, 16'h0000};
		@(posedge clk);
		{we, rd} <= 2'b01;
		q.push_back(16'h0000);
		@(posedge clk);
		{rd, clr} <= 2'b01;
		@(posedge clk);
		clr <= 0;
		@(posedge clk);
		chk(stk, 1'b1);
		$display("clear test done");
		srst <= 1;
		@(posedge clk);
		srst <= 0;
		@(posedge clk);
		chk(stk, 1'b0);
		chk(word, 16'h0000);
		chk(bok, 1'b0);
		chk(vq, 1'b0);
		@(posedge clk);
		chk(q.size(), 0);
		$display("reset test done");
		give_verdict;
	end
endmodule
